// ### core/extended_data_address_select.sv
/*
 * Data address selector for byte, bit and indirect operations, with the
 * indexed literal offset mode of the extended instruction set.
 * Assumes decode flags, opcode, pointers and bank come from core logic
 * on clk_sys; the address is registered on the edge after the request.
 */
// Function
// [RQ1] Remapping only when extended set enabled
// [RQ2] a=0, operand up to 5Fh: offset mode
// [RQ3] Offset plus third pointer forms target
// [RQ4] a=0, operand 60h up: access bank
// [RQ5] a=1: bank register plus operand
// [RQ6] Forced mode never reaches access below 60h
// [RQ7] Inherent and literal instructions unchanged
// [RQ8] Indirect through pointers zero, one unchanged
// [RQ9] Memory size and map unchanged
// [RQ10] Low 96 locations map to pointer window
// [RQ11] a=1 keeps bank addressing for low operands
// [RQ12] d bit 9, a bit 8, operand low byte
// [RQ13] Eight added instructions recognised when enabled
// [RQ14] Long mode concatenates bank and operand
// [RQ15] Pointers hold 12 bits, spanning memory
// [RQ16] Indexed sum wraps, pointer untouched
// [RQ17] Address formed combinationally per request; the code registers it on the next clk_sys edge
`timescale 1ns/100ps
module extended_data_address_select (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic extended_set_enable,
    input wire logic opcode_valid,
    input wire logic [ext_addr_pkg::OPCODE_W-1:0] opcode,
    input wire logic file_access,
    input wire logic indirect_access,
    input wire ext_addr_pkg::pointer_select_type indirect_select,
    input wire logic [ext_addr_pkg::ADDR_W-1:0] indirect_pointer_zero,
    input wire logic [ext_addr_pkg::ADDR_W-1:0] indirect_pointer_one,
    input wire logic [ext_addr_pkg::ADDR_W-1:0] index_pointer_two,
    input wire logic [ext_addr_pkg::BANK_W-1:0] bank_select_register,
    output logic address_valid,
    output logic [ext_addr_pkg::ADDR_W-1:0] target_address,
    output ext_addr_pkg::address_mode_type address_mode,
    output logic dest_to_file,
    output logic extended_opcode
);
    import ext_addr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode fields and added-instruction decode

    logic [OPERAND_W-1:0] file_operand;
    logic access_bit;
    logic dest_bit;
    logic [EXT_COUNT-1:0] ext_hit;
    logic is_extended;

    assign file_operand = opcode[OPERAND_W-1:0]; // RQ12
    assign access_bit = opcode[ACCESS_BIT]; // RQ12
    assign dest_bit = opcode[DEST_BIT]; // RQ12

    genvar gi;
    generate
        for (gi = 0; gi < EXT_COUNT; gi++) begin : g_ext
            assign ext_hit[gi] = (opcode & EXT_MASK[gi]) == EXT_MATCH[gi];
        end
    endgenerate
    assign is_extended = extended_set_enable && (|ext_hit); // RQ13

    ////////////////////////////////////////////////////////////////////////////
    // Address calculation

    addr_calc_if calc_bus ();

    assign calc_bus.enable = extended_set_enable;
    assign calc_bus.access_bank_n = access_bit;
    assign calc_bus.operand = file_operand;
    assign calc_bus.bank = bank_select_register;
    assign calc_bus.index_base = index_pointer_two; // RQ15

    addr_mode_calc u_calc (
        .bus(calc_bus)
    );

    logic [ADDR_W-1:0] indirect_addr;
    logic next_valid;
    logic [ADDR_W-1:0] next_target;
    address_mode_type next_mode;
    logic next_dest;
    logic next_extended;

    // Indirect pointers bypass banking and the enable entirely
    assign indirect_addr = (indirect_select == PTR_ZERO) ? indirect_pointer_zero
        : (indirect_select == PTR_ONE) ? indirect_pointer_one
        : index_pointer_two; // RQ8

    // Indirect wins over a file operand; otherwise no data address
    assign next_valid = opcode_valid && (indirect_access || file_access); // RQ7
    assign next_mode = !opcode_valid ? MODE_NONE
        : indirect_access ? MODE_INDIRECT
        : file_access ? calc_bus.mode : MODE_NONE; // RQ7 RQ17
    assign next_target = !next_valid ? target_address
        : indirect_access ? indirect_addr : calc_bus.address; // RQ17
    assign next_dest = opcode_valid ? dest_bit : dest_to_file;
    assign next_extended = opcode_valid && is_extended; // RQ13

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            address_valid <= 1'b0;
            target_address <= ADDR_RESET;
            address_mode <= MODE_NONE;
            dest_to_file <= 1'b0;
            extended_opcode <= 1'b0;
        end else begin
            address_valid <= next_valid;
            target_address <= next_target;
            address_mode <= next_mode;
            dest_to_file <= next_dest;
            extended_opcode <= next_extended;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    logic file_req;
    logic [ADDR_W-1:0] last_pointer_two;
    logic [ADDR_W-1:0] window_distance;
    assign file_req = opcode_valid && file_access && !indirect_access;

    // Pointer two as seen by the request behind the current target
    always_ff @(posedge clk_sys) begin
        last_pointer_two <= index_pointer_two;
    end
    assign window_distance = target_address - last_pointer_two;

    AST_INDEXED_SUM: assert property ( // RQ3
        file_req && extended_set_enable && !access_bit && in_offset_range(file_operand)
        |=> address_mode == MODE_INDEXED
            && target_address == $past(index_pointer_two) + 12'($past(file_operand))
    ) else $error("indexed address is not pointer plus offset");

    AST_INDEX_NEEDS_ENABLE: assert property ( // RQ1
        opcode_valid && !extended_set_enable |=> address_mode != MODE_INDEXED
    ) else $error("indexed mode used with extended set off");

    AST_LOW_OPERAND_INDEXED: assert property ( // RQ2
        file_req && extended_set_enable && !access_bit && file_operand <= 8'h5f
        |=> address_mode == MODE_INDEXED
    ) else $error("low forced operand not taken as offset");

    AST_FORCED_BANK_ZERO: assert property ( // RQ4
        file_req && !access_bit && file_operand >= 8'h60 && file_operand <= 8'h7f
        |=> address_mode == MODE_FORCED && target_address == {4'h0, $past(file_operand)}
    ) else $error("forced operand 60h-7Fh not in bank 0");

    AST_FORCED_BANK_TOP: assert property ( // RQ4
        file_req && !access_bit && file_operand >= 8'h80
        |=> target_address >= 12'hf80 && target_address[7:0] == $past(file_operand)
    ) else $error("forced operand 80h-FFh not in F80h-FFFh");

    AST_DISABLED_FORCED_LOW: assert property ( // RQ9
        file_req && !extended_set_enable && !access_bit && file_operand < 8'h60
        |=> address_mode == MODE_FORCED && target_address == {4'h0, $past(file_operand)}
    ) else $error("core access mapping altered with extended set off");

    AST_FORCED_NO_LOW: assert property ( // RQ6
        address_valid && address_mode == MODE_FORCED && $past(extended_set_enable)
        |-> (target_address >= 12'h060 && target_address <= 12'h07f)
            || target_address >= 12'hf80
    ) else $error("forced mode reached access below 60h");

    AST_LONG_CONCAT: assert property ( // RQ5
        file_req && access_bit
        |=> address_mode == MODE_LONG
            && target_address == {$past(bank_select_register), $past(file_operand)}
    ) else $error("long address is not bank and operand");

    AST_INHERENT_NONE: assert property ( // RQ7
        opcode_valid && !file_access && !indirect_access
        |=> !address_valid && address_mode == MODE_NONE
            && $stable(target_address)
    ) else $error("inherent instruction produced a data address");

    AST_INDIRECT_PTR: assert property ( // RQ8
        opcode_valid && indirect_access && indirect_select != PTR_TWO
        |=> address_mode == MODE_INDIRECT
            && target_address == ($past(indirect_select) == PTR_ZERO
                ? $past(indirect_pointer_zero) : $past(indirect_pointer_one))
    ) else $error("indirect address differs from selected pointer");

    AST_WINDOW_SPAN: assert property ( // RQ10
        address_valid && address_mode == MODE_INDEXED |-> window_distance <= 12'd95
    ) else $error("indexed target outside pointer window");

    AST_DEST_FIELD: assert property ( // RQ12
        opcode_valid ##1 address_valid |-> dest_to_file == $past(opcode[9])
    ) else $error("destination bit not taken from opcode bit 9");

    AST_EXT_ENABLED: assert property ( // RQ13
        extended_opcode |-> $past(extended_set_enable) && $past(opcode_valid)
    ) else $error("added instruction flagged with extended set off");

    AST_NEXT_EDGE: assert property ( // RQ17
        opcode_valid && (file_access || indirect_access) |=> address_valid
    ) else $error("address not ready on the following edge");

    AST_INDIRECT_TWO: assert property ( // RQ8
        opcode_valid && indirect_access && indirect_select == PTR_TWO
        |=> address_mode == MODE_INDIRECT && target_address == $past(index_pointer_two)
    ) else $error("indirect address differs from pointer two");

    AST_EXT_NEEDS_ENABLE: assert property ( // RQ13
        opcode_valid && !extended_set_enable |=> !extended_opcode
    ) else $error("added instruction recognised while disabled");

    AST_IDLE_HOLDS: assert property ( // RQ17
        !opcode_valid |=> !address_valid && address_mode == MODE_NONE && !extended_opcode
            && $stable(target_address) && $stable(dest_to_file)
    ) else $error("outputs changed without a request");

    COV_INDEXED: cover property (address_valid && address_mode == MODE_INDEXED);
    COV_FORCED_TOP: cover property (address_mode == MODE_FORCED && target_address >= 12'hf80);
    COV_LONG: cover property (address_valid && address_mode == MODE_LONG);
    COV_WRAP: cover property (
        address_mode == MODE_INDEXED && target_address < $past(index_pointer_two));
    COV_EXTENDED: cover property (extended_opcode);

endmodule // extended_data_address_select

// ### core/ext_addr_pkg.sv
/*
 * Constants, types and shared decode functions for the extended-set data
 * address selector.
 * Assumes a 12-bit linear data space split into sixteen 256-byte banks.
 */
package ext_addr_pkg;

    localparam int ADDR_W = 12;
    localparam int OPERAND_W = 8;
    localparam int BANK_W = 4;
    localparam int OPCODE_W = 16;
    localparam int DEST_BIT = 9;
    localparam int ACCESS_BIT = 8;
    localparam int EXT_COUNT = 8;
    localparam int WINDOW_SPAN = 95;

    localparam logic [OPERAND_W-1:0] OFFSET_LIMIT = 8'h5f;
    localparam logic [OPERAND_W-1:0] ACCESS_SPLIT = 8'h80;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // Match and mask pairs for the added instructions
    localparam logic [EXT_COUNT-1:0][OPCODE_W-1:0] EXT_MATCH = {
        16'he800, 16'he840, 16'he880, 16'he8c0,
        16'he900, 16'he940, 16'hea00, 16'heb00
    };
    localparam logic [EXT_COUNT-1:0][OPCODE_W-1:0] EXT_MASK = {
        16'hffc0, 16'hffc0, 16'hffc0, 16'hffc0,
        16'hffc0, 16'hffc0, 16'hff00, 16'hff00
    };

    typedef enum logic [2:0] {
        MODE_NONE = 3'b000,
        MODE_INDEXED = 3'b001,
        MODE_FORCED = 3'b010,
        MODE_LONG = 3'b011,
        MODE_INDIRECT = 3'b100
    } address_mode_type;

    typedef enum logic [1:0] {
        PTR_ZERO = 2'b00,
        PTR_ONE = 2'b01,
        PTR_TWO = 2'b10
    } pointer_select_type;

    function automatic logic in_offset_range(input logic [OPERAND_W-1:0] f);
        return f <= OFFSET_LIMIT;
    endfunction

    // Access bank: low half in bank 0, high half in bank 15
    function automatic logic [ADDR_W-1:0] forced_address(input logic [OPERAND_W-1:0] f);
        return {(f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK, f};
    endfunction

endpackage

// ### core/addr_calc_if.sv
/*
 * Carrier between the selector top and its address calculator.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
interface addr_calc_if;
    import ext_addr_pkg::*;
    logic enable;
    logic access_bank_n;
    logic [OPERAND_W-1:0] operand;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] index_base;
    address_mode_type mode;
    logic [ADDR_W-1:0] address;

    modport calc (
        input enable,
        input access_bank_n,
        input operand,
        input bank,
        input index_base,
        output mode,
        output address
    );
    modport user (
        output enable,
        output access_bank_n,
        output operand,
        output bank,
        output index_base,
        input mode,
        input address
    );
endinterface

// ### core/addr_mode_calc.sv
/*
 * Combinational mode choice and address forming for file operands.
 * Assumes the caller only uses the result for byte or bit operations.
 */
`timescale 1ns/100ps
module addr_mode_calc (
    addr_calc_if.calc bus
);
    import ext_addr_pkg::*;

    logic use_index;
    logic [ADDR_W-1:0] index_sum;
    logic [ADDR_W-1:0] long_addr;

    // Offset mode only when enabled, access forced and operand low
    assign use_index = bus.enable && !bus.access_bank_n
        && in_offset_range(bus.operand); // RQ1 RQ2 RQ6
    // Sum wraps in 12 bits; pointer itself is never written
    assign index_sum = bus.index_base + {{(ADDR_W-OPERAND_W){1'b0}}, bus.operand}; // RQ3 RQ16
    assign long_addr = {bus.bank, bus.operand}; // RQ5 RQ14

    assign bus.mode = bus.access_bank_n ? MODE_LONG
        : (use_index ? MODE_INDEXED : MODE_FORCED); // RQ11
    assign bus.address = bus.access_bank_n ? long_addr
        : (use_index ? index_sum : forced_address(bus.operand)); // RQ4 RQ9 RQ10

endmodule // addr_mode_calc

// ### sim/core_decode_model.sv
/*
 * Far-side model: core decode stage presenting instructions, pointers and bank.
 * Assumes the selector samples every input on the rising edge of clk_sys.
 */
`timescale 1ns/100ps
module core_decode_model (
    input wire logic clk_sys,
    output logic extended_set_enable,
    output logic opcode_valid,
    output logic [ext_addr_pkg::OPCODE_W-1:0] opcode,
    output logic file_access,
    output logic indirect_access,
    output ext_addr_pkg::pointer_select_type indirect_select,
    output logic [ext_addr_pkg::ADDR_W-1:0] indirect_pointer_zero,
    output logic [ext_addr_pkg::ADDR_W-1:0] indirect_pointer_one,
    output logic [ext_addr_pkg::ADDR_W-1:0] index_pointer_two,
    output logic [ext_addr_pkg::BANK_W-1:0] bank_select_register
);
    import ext_addr_pkg::*;

    initial begin
        {extended_set_enable, opcode_valid, file_access, indirect_access} = 4'h0;
        opcode = 16'h0000;
        indirect_select = PTR_ZERO;
        {indirect_pointer_zero, indirect_pointer_one, index_pointer_two} = 36'h0;
        bank_select_register = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic set_state(input logic en, input logic [11:0] p0, input logic [11:0] p1,
                             input logic [11:0] p2, input logic [3:0] bk);
        @(posedge clk_sys);
        extended_set_enable <= en;
        indirect_pointer_zero <= p0;
        indirect_pointer_one <= p1;
        index_pointer_two <= p2;
        bank_select_register <= bk;
    endtask

    // One-cycle request; opcode scrambled once released
    task automatic issue(input logic [15:0] op, input logic fa, input logic ia,
                         input pointer_select_type sel);
        @(posedge clk_sys);
        opcode_valid <= 1'b1;
        opcode <= op;
        file_access <= fa;
        indirect_access <= ia;
        indirect_select <= sel;
        @(posedge clk_sys);
        opcode_valid <= 1'b0;
        opcode <= ~op;
        file_access <= 1'b0;
        indirect_access <= 1'b0;
    endtask
endmodule // core_decode_model

// ### sim/tb.sv
/*
 * Self-checking bench for the extended-set data address selector.
 * Assumes core_decode_model drives all requests and pointer state.
 */
`timescale 1ns/100ps
module tb;
    import ext_addr_pkg::*;

    logic clk_sys;
    logic nrst;
    logic extended_set_enable;
    logic opcode_valid;
    logic [OPCODE_W-1:0] opcode;
    logic file_access;
    logic indirect_access;
    pointer_select_type indirect_select;
    logic [ADDR_W-1:0] indirect_pointer_zero;
    logic [ADDR_W-1:0] indirect_pointer_one;
    logic [ADDR_W-1:0] index_pointer_two;
    logic [BANK_W-1:0] bank_select_register;
    logic address_valid;
    logic [ADDR_W-1:0] target_address;
    address_mode_type address_mode;
    logic dest_to_file;
    logic extended_opcode;
    int err_total;
    int samples_checked;
    logic [11:0] ptrs [3] = '{12'h123, 12'h456, 12'hfd0};

    core_decode_model core (.clk_sys, .extended_set_enable, .opcode_valid, .opcode,
        .file_access, .indirect_access, .indirect_select, .indirect_pointer_zero,
        .indirect_pointer_one, .index_pointer_two, .bank_select_register);

    extended_data_address_select dut (.clk_sys, .nrst, .extended_set_enable,
        .opcode_valid, .opcode, .file_access, .indirect_access, .indirect_select,
        .indirect_pointer_zero, .indirect_pointer_one, .index_pointer_two,
        .bank_select_register, .address_valid, .target_address, .address_mode,
        .dest_to_file, .extended_opcode);

    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("mismatches %0d, checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One request, then the registered answer one cycle later
    task automatic probe(input logic [15:0] op, input logic fa, input logic ia,
                         input pointer_select_type sel, input logic [11:0] ea,
                         input logic [2:0] em, input logic ev, input logic ex);
        core.issue(op, fa, ia, sel);
        #1;
        check(address_valid, ev);
        check(address_mode, em);
        check(extended_opcode, ex);
        if (ev) begin
            check(target_address, ea);
            check(dest_to_file, op[9]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end

    initial begin
        clk_sys = 1'b0;
        nrst = 1'b0;
        err_total = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        check(address_valid, 0);
        check(address_mode, 0);
        check(target_address, 0);
        check(dest_to_file, 0);
        check(extended_opcode, 0);
        for (int e = 0; e < 2; e++) begin
            core.set_state(e[0], ptrs[0], ptrs[1], ptrs[2], 4'h7);
            for (int s = 0; s < 3; s++) begin
                probe(16'h2410, 1, 1, pointer_select_type'(s), ptrs[s], 3'b100, 1, 0);
            end
            for (int i = 0; i < EXT_COUNT; i++) begin
                probe(EXT_MATCH[i], 0, 0, PTR_ZERO, 12'h000, 3'b000, 0, e[0]);
            end
        end
        probe(16'h2610, 1, 0, PTR_ZERO, 12'hfe0, 3'b001, 1, 0);
        probe(16'h245f, 1, 0, PTR_ZERO, 12'h02f, 3'b001, 1, 0);
        probe(16'h2460, 1, 0, PTR_ZERO, 12'h060, 3'b010, 1, 0);
        probe(16'h247f, 1, 0, PTR_ZERO, 12'h07f, 3'b010, 1, 0);
        probe(16'h2480, 1, 0, PTR_ZERO, 12'hf80, 3'b010, 1, 0);
        probe(16'h24ff, 1, 0, PTR_ZERO, 12'hfff, 3'b010, 1, 0);
        probe(16'h2510, 1, 0, PTR_ZERO, 12'h710, 3'b011, 1, 0);
        probe(16'h2700, 1, 0, PTR_ZERO, 12'h700, 3'b011, 1, 0);
        @(posedge clk_sys);
        #1;
        check(address_valid, 0);
        check(target_address, 12'h700);
        probe(16'h0e55, 0, 0, PTR_ZERO, 12'h000, 3'b000, 0, 0);
        probe(16'h2410, 1, 0, PTR_ZERO, 12'hfe0, 3'b001, 1, 0);
        core.set_state(1'b0, ptrs[0], ptrs[1], ptrs[2], 4'h3);
        probe(16'h2610, 1, 0, PTR_ZERO, 12'h010, 3'b010, 1, 0);
        probe(16'h245f, 1, 0, PTR_ZERO, 12'h05f, 3'b010, 1, 0);
        probe(16'h24c0, 1, 0, PTR_ZERO, 12'hfc0, 3'b010, 1, 0);
        probe(16'h2510, 1, 0, PTR_ZERO, 12'h310, 3'b011, 1, 0);
        wrap_up();
    end
endmodule // tb
